// file: rtl/wdtu_top.sv
// Summary of operation
// - mode 11: watchdog always runs, also in sleep, enable bit ignored.
// - mode 10: runs while awake, disabled during sleep.
// - mode 01: runs only while software enable bit is set.
// - enable bit ignored in modes 1x and 00; mode 00 always off.
// - control: period select bits 5..1, enable bit 0, bits 7..6 zero.
// - codes 0..18 give prescale ratio 32 shifted left by code.
// - codes 19..31 give the minimum ratio of 32.
// - any reset loads period code 01011, a ratio of 65536.
// - count advances only on low-frequency oscillator ticks.
// - count cleared on reset, oscillator failure, and while disabled.
// - clear instruction clears count; firmware must issue it in time.
// - entering sleep clears count; counting resumes if still enabled.
// - waking clears count; held clear while start-up timer runs.
// - internal oscillator divider changes leave the count alone.
// - time-out in sleep wakes core, no reset, updates both flags.
// - time-out while awake issues a system reset.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "wdtu_cfg.svh"

module wdtu_top (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// register port
	input wire logic [`WDTU_AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// configuration and core state
	input wire logic [1:0] i_wdt_mode_cfg,
	input wire logic i_sleep,
	input wire logic i_ost_running,
	// clear sources
	input wire logic i_clear_watchdog_instr,
	input wire logic i_osc_fail,
	// low-frequency oscillator tick, one cycle wide
	input wire logic i_lf_tick,
	// results
	output logic o_wdt_reset,
	output logic o_wake,
	output logic o_timeout_flag_n,
	output logic o_powerdown_flag_n,
	output logic o_irq
);

	wdtu_pkg::wdtu_mode_e mode;
	logic [4:0] period_select;
	logic sw_watchdog_enable;
	logic [4:0] next_period_select;
	logic next_sw_watchdog_enable;
	logic [`WDTU_EV_W-1:0] ev_stat;
	logic [`WDTU_EV_W-1:0] ev_mask;
	logic [`WDTU_EV_W-1:0] next_ev_stat;
	logic [`WDTU_EV_W-1:0] next_ev_mask;
	logic [7:0] next_rdata;
	logic [`WDTU_CNT_W-1:0] count;
	logic [`WDTU_CNT_W-1:0] next_count;
	logic [`WDTU_CNT_W-1:0] ratio;
	logic sleep_q;
	logic enabled;
	logic clr;
	logic hit;
	logic next_wdt_reset;
	logic next_wake;
	logic next_to_n;
	logic next_pd_n;
	logic next_irq;
	logic stat_rd;

	assign mode = wdtu_pkg::wdtu_mode_e'(i_wdt_mode_cfg);

	// run decision from configuration, sleep state and software bit
	always_comb begin
		enabled = 1'b0;
		unique case (mode)
			wdtu_pkg::WDTU_MODE_ON: begin
				enabled = 1'b1;
			end
			wdtu_pkg::WDTU_MODE_NOSLEEP: begin
				enabled = ~i_sleep;
			end
			wdtu_pkg::WDTU_MODE_SW: begin
				enabled = sw_watchdog_enable;
			end
			wdtu_pkg::WDTU_MODE_OFF: begin
				enabled = 1'b0;
			end
		endcase
	end

	// prescale ratio; reserved codes fall back to the shortest interval
	always_comb begin
		if (period_select <= `WDTU_PS_MAX) begin
			ratio = `WDTU_RATIO_BASE << period_select;
		end else begin
			ratio = `WDTU_RATIO_BASE;
		end
	end

	// any sleep edge clears; start-up timer holds clear after wake
	assign clr = i_clear_watchdog_instr
		| i_osc_fail
		| ~enabled
		| (i_sleep ^ sleep_q)
		| (~i_sleep & i_ost_running);

	// only oscillator ticks count, so core clock changes do not matter
	assign hit = enabled & ~clr & i_lf_tick & (count == ratio - `WDTU_RATIO_BASE / `WDTU_RATIO_BASE);

	// counter
	always_comb begin
		next_count = count;
		if (clr) begin
			next_count = '0;
		end else if (hit) begin
			next_count = '0;
		end else if (i_lf_tick) begin
			next_count = `WDTU_CNT_W'(count + 1'b1);
		end
	end

	// no divider input here: a divider change cannot disturb the count
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			count <= '0;
			sleep_q <= 1'b0;
		end else begin
			count <= next_count;
			sleep_q <= i_sleep;
		end
	end

	// time-out outcome and status flags
	always_comb begin
		next_wdt_reset = hit & ~i_sleep;
		next_wake = hit & i_sleep;
		next_to_n = o_timeout_flag_n;
		next_pd_n = o_powerdown_flag_n;
		if (i_clear_watchdog_instr) begin
			next_to_n = 1'b1;
			next_pd_n = 1'b1;
		end
		if (i_sleep & ~sleep_q) begin
			next_pd_n = 1'b0;
		end
		// time-out last, but hit is gated by clr, so a clear in the same cycle wins
		if (hit) begin
			next_to_n = 1'b0;
			next_pd_n = ~i_sleep;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_wdt_reset <= 1'b0;
			o_wake <= 1'b0;
			o_timeout_flag_n <= 1'b1;
			o_powerdown_flag_n <= 1'b1;
		end else begin
			o_wdt_reset <= next_wdt_reset;
			o_wake <= next_wake;
			o_timeout_flag_n <= next_to_n;
			o_powerdown_flag_n <= next_pd_n;
		end
	end

	// register file
	assign stat_rd = i_rd & (i_addr == `WDTU_OFS_STAT);

	always_comb begin
		next_period_select = period_select;
		next_sw_watchdog_enable = sw_watchdog_enable;
		next_ev_mask = ev_mask;
		if (i_wr & (i_addr == `WDTU_OFS_CTRL)) begin
			next_period_select = i_wdata[`WDTU_PS_MSB:`WDTU_PS_LSB];
			next_sw_watchdog_enable = i_wdata[`WDTU_SWEN_BIT];
		end
		if (i_wr & (i_addr == `WDTU_OFS_MASK)) begin
			next_ev_mask = i_wdata[`WDTU_EV_W-1:0];
		end
	end

	// read clears status, but an event in the same cycle survives
	always_comb begin
		next_ev_stat = ev_stat;
		if (stat_rd) begin
			next_ev_stat = '0;
		end
		next_ev_stat[`WDTU_EV_RESET] = next_ev_stat[`WDTU_EV_RESET] | next_wdt_reset;
		next_ev_stat[`WDTU_EV_WAKE] = next_ev_stat[`WDTU_EV_WAKE] | next_wake;
		next_irq = |(next_ev_stat & next_ev_mask);
	end

	// reads answer one cycle later; unmapped words never exist here
	always_comb begin
		next_rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`WDTU_OFS_CTRL: begin
					next_rdata = {2'h0, period_select, sw_watchdog_enable};
				end
				`WDTU_OFS_STAT: begin
					next_rdata = {6'h00, ev_stat};
				end
				`WDTU_OFS_MASK: begin
					next_rdata = {6'h00, ev_mask};
				end
				`WDTU_OFS_FLAG: begin
					next_rdata = {6'h00, o_timeout_flag_n, o_powerdown_flag_n};
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			period_select <= 5'(`WDTU_CTRL_RST >> `WDTU_PS_LSB);
			sw_watchdog_enable <= 1'b0;
			ev_stat <= '0;
			ev_mask <= '0;
			o_rdata <= 8'h00;
			o_irq <= 1'b0;
		end else begin
			period_select <= next_period_select;
			sw_watchdog_enable <= next_sw_watchdog_enable;
			ev_stat <= next_ev_stat;
			ev_mask <= next_ev_mask;
			o_rdata <= next_rdata;
			o_irq <= next_irq;
		end
	end

	// checks
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	property p_always_on;
		mode == wdtu_pkg::WDTU_MODE_ON & i_lf_tick & ~clr & ~hit |=> count == $past(count) + 1'b1;
	endproperty
	a_always_on: assert property (p_always_on) else $error("always-on mode did not count");

	property p_nosleep;
		mode == wdtu_pkg::WDTU_MODE_NOSLEEP & i_sleep & sleep_q |=> count == '0;
	endproperty
	a_nosleep: assert property (p_nosleep) else $error("count moved during sleep");

	property p_sw;
		mode == wdtu_pkg::WDTU_MODE_SW |-> enabled == sw_watchdog_enable;
	endproperty
	a_sw: assert property (p_sw) else $error("software mode run state wrong");

	property p_off;
		mode == wdtu_pkg::WDTU_MODE_OFF |=> count == '0 && !o_wdt_reset && !o_wake;
	endproperty
	a_off: assert property (p_off) else $error("off mode not idle");

	property p_rsvd;
		i_rd & (i_addr == `WDTU_OFS_CTRL) |=> o_rdata[7:6] == 2'h0 && o_rdata[5:1] == $past(period_select);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("control read back wrong");

	property p_ratio;
		period_select > `WDTU_PS_MAX |-> ratio == `WDTU_RATIO_BASE;
	endproperty
	a_ratio: assert property (p_ratio) else $error("reserved code ratio wrong");

	property p_clear;
		i_clear_watchdog_instr |=> count == '0 && !o_wdt_reset && !o_wake;
	endproperty
	a_clear: assert property (p_clear) else $error("clear instruction ignored");

	property p_sleep_edge;
		$changed(i_sleep) |=> count == '0;
	endproperty
	a_sleep_edge: assert property (p_sleep_edge) else $error("sleep edge did not clear");

	property p_ost;
		~i_sleep & i_ost_running |=> count == '0;
	endproperty
	a_ost: assert property (p_ost) else $error("count moved under start-up timer");

	sequence s_sleep_hit;
		hit & i_sleep;
	endsequence
	sequence s_wake_out;
		o_wake && !o_wdt_reset && !o_timeout_flag_n && !o_powerdown_flag_n ##1 !o_wake;
	endsequence
	property p_wake;
		s_sleep_hit |=> s_wake_out;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep time-out misbehaved");

	sequence s_awake_hit;
		hit & ~i_sleep;
	endsequence
	property p_reset;
		s_awake_hit |=> o_wdt_reset && !o_wake ##1 !o_wdt_reset;
	endproperty
	a_reset: assert property (p_reset) else $error("awake time-out gave no reset pulse");

	property p_restart;
		hit |=> count == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("count did not restart");

	property p_ratio_code;
		period_select <= `WDTU_PS_MAX |-> ratio == `WDTU_RATIO_BASE * (`WDTU_CNT_W'(1) << period_select);
	endproperty
	a_ratio_code: assert property (p_ratio_code) else $error("valid code ratio wrong");

	property p_osc_fail;
		i_osc_fail |=> count == '0;
	endproperty
	a_osc_fail: assert property (p_osc_fail) else $error("oscillator failure did not clear");

	// no tick means no movement, whatever the core clock does
	property p_no_tick;
		!i_lf_tick && !clr |=> count == $past(count);
	endproperty
	a_no_tick: assert property (p_no_tick) else $error("count moved without a tick");

	property p_hit_point;
		hit |-> count + 1'b1 == ratio;
	endproperty
	a_hit_point: assert property (p_hit_point) else $error("time-out at wrong count");

	property p_on_sleep;
		mode == wdtu_pkg::WDTU_MODE_ON & i_sleep |-> enabled;
	endproperty
	a_on_sleep: assert property (p_on_sleep) else $error("always-on mode stopped in sleep");

	property p_ctrl_write;
		i_wr && i_addr == `WDTU_OFS_CTRL |-> next_period_select == i_wdata[`WDTU_PS_MSB:`WDTU_PS_LSB]
			&& next_sw_watchdog_enable == i_wdata[`WDTU_SWEN_BIT];
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_clear_flags;
		i_clear_watchdog_instr & ~(i_sleep & ~sleep_q) |=> o_timeout_flag_n && o_powerdown_flag_n;
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("clear instruction kept flags");

	property p_awake_flags;
		s_awake_hit |=> !o_timeout_flag_n && o_powerdown_flag_n;
	endproperty
	a_awake_flags: assert property (p_awake_flags) else $error("awake time-out flags wrong");

	property p_sleep_pd;
		i_sleep & ~sleep_q |=> !o_powerdown_flag_n;
	endproperty
	a_sleep_pd: assert property (p_sleep_pd) else $error("sleep entry kept power-down flag");

	property p_stat_clear;
		stat_rd && !hit |=> ev_stat == '0;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");

	// set wins over a read in the same cycle
	property p_stat_sticky;
		hit |=> ev_stat != '0;
	endproperty
	a_stat_sticky: assert property (p_stat_sticky) else $error("time-out left no status");

	property p_irq;
		o_irq == |(ev_stat & ev_mask);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	property p_rdata_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

endmodule

`default_nettype wire

// file: shared/wdtu_cfg.svh
`ifndef WDTU_CFG_SVH
`define WDTU_CFG_SVH

// register map, word index on the plain port
`define WDTU_AW 2
`define WDTU_OFS_CTRL 2'h0
`define WDTU_OFS_STAT 2'h1
`define WDTU_OFS_MASK 2'h2
`define WDTU_OFS_FLAG 2'h3

// control register layout
`define WDTU_CTRL_RST 8'h16
`define WDTU_SWEN_BIT 0
`define WDTU_PS_LSB 1
`define WDTU_PS_MSB 5

// period select decode
`define WDTU_PS_MAX 5'h12
`define WDTU_RATIO_BASE 24'h000020
`define WDTU_CNT_W 24

// event status bits
`define WDTU_EV_W 2
`define WDTU_EV_RESET 0
`define WDTU_EV_WAKE 1

`endif

// file: shared/wdtu_pkg.sv
`default_nettype none
package wdtu_pkg;
	// mode code order matches the two-bit configuration field
	typedef enum logic [1:0] {
		WDTU_MODE_OFF,
		WDTU_MODE_SW,
		WDTU_MODE_NOSLEEP,
		WDTU_MODE_ON
	} wdtu_mode_e;
	typedef logic [7:0] wdtu_byte_t;
endpackage
`default_nettype wire

// file: test/wdtu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module wdtu_core_model (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// core requests
	input wire logic i_sleep_cmd,
	input wire logic i_wake,
	// to the watchdog
	output logic o_sleep,
	output logic o_lf_tick
);
	logic woke;
	logic phase;
	logic next_woke;
	logic next_phase;
	always_comb begin
		next_phase = ~phase;
		// a wake ends sleep until the core asks again
		next_woke = i_wake | (woke & i_sleep_cmd);
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			woke <= 1'b0;
			phase <= 1'b0;
		end else begin
			woke <= next_woke;
			phase <= next_phase;
		end
	end
	// tick every second cycle, so ticks and cycles differ
	assign o_lf_tick = phase;
	assign o_sleep = i_sleep_cmd & ~woke;
endmodule
`default_nettype wire

// file: test/wdtu_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module wdtu_top_test;
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, clr = 1'b0, fail = 1'b0, osc_startup_timer = 1'b0, scmd = 1'b0;
	logic [1:0] addr = 2'h0, mode = 2'h0;
	logic [7:0] wdata = 8'h00, rdata, d;
	logic sleep, tick, rst_o, wake, to_n, pd_n, irq, r, w;
	logic [4:0] c;
	logic [31:0] n;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	wdtu_top dut (.i_mclk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata), .i_wdt_mode_cfg(mode), .i_sleep(sleep), .i_ost_running(osc_startup_timer),
		.i_clear_watchdog_instr(clr), .i_osc_fail(fail), .i_lf_tick(tick), .o_wdt_reset(rst_o),
		.o_wake(wake), .o_timeout_flag_n(to_n), .o_powerdown_flag_n(pd_n), .o_irq(irq));
	wdtu_core_model core (.i_mclk(clk), .i_rst(rst), .i_sleep_cmd(scmd), .i_wake(wake), .o_sleep(sleep),
		.o_lf_tick(tick));
	initial begin
		forever #5 clk = ~clk;
	end
	// hang guard, well above the longest sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end
	function automatic logic [31:0] ratio(input logic [4:0] code);
		return (code > 5'h12) ? 32'h20 : (32'h20 << code);
	endfunction
	function automatic logic active(input int m, input logic en, input logic sl);
		return m == 3 || (m == 2 && !sl) || (m == 1 && en);
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task reg_wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task reg_rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
	endtask
	task clear_wd;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	// ticks seen until a time-out pulse, or the bound runs out
	task measure;
		n = 32'h0;
		r = 1'b0;
		w = 1'b0;
		repeat (1200) begin
			@(negedge clk);
			if (rst_o === 1'b1 || wake === 1'b1) begin
				r = rst_o;
				w = wake;
				break;
			end
			if (tick === 1'b1) n++;
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(71737));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		reg_rd(2'h0, d);
		chk("ctrl reset", 8'h16, d);
		chk("flags reset", 3'h6, {to_n, pd_n, irq});
		reg_wr(2'h0, 8'hFF);
		reg_rd(2'h0, d);
		chk("ctrl bits", 8'h3F, d);
		do_reset();
		reg_rd(2'h0, d);
		chk("ctrl rereset", 8'h16, d);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 4; k++) begin
				@(posedge clk);
				mode <= m[1:0];
				reg_wr(2'h0, {7'h00, k[0]});
				scmd <= k[1];
				repeat (3) @(posedge clk);
				clear_wd();
				measure();
				chk("reset pulse", active(m, k[0], k[1]) & !k[1], r);
				chk("wake pulse", active(m, k[0], k[1]) & k[1], w);
				if (w === 1'b1) chk("sleep flags", 2'h0, {to_n, pd_n});
				if (r === 1'b1 || w === 1'b1) chk("ticks", 32'h20, n);
				@(posedge clk);
				scmd <= 1'b0;
				clear_wd();
			end
		end
		$display("test modes done");
		mode <= 2'h3;
		for (int i = 0; i < 7; i++) begin
			c = (i < 4) ? 5'(i) : (i == 4) ? 5'($urandom % 4) : (i == 5) ? 5'(19 + $urandom % 13) : 5'h1F;
			reg_wr(2'h0, {2'h0, c, 1'b0});
			reg_rd(2'h0, d);
			chk("ctrl code", {2'h0, c, 1'b0}, d);
			clear_wd();
			measure();
			chk("ratio", ratio(c), n);
			chk("awake reset", 1'b1, r);
		end
		$display("test periods done");
		reg_wr(2'h0, 8'h00);
		for (int s = 0; s < 3; s++) begin
			@(posedge clk);
			{osc_startup_timer, fail, clr} <= 3'h1 << s;
			measure();
			chk("held clear", 1'b0, r);
			@(posedge clk);
			{osc_startup_timer, fail, clr} <= 3'h0;
			measure();
			chk("after clear", 32'h20, n);
		end
		$display("test clears done");
		reg_rd(2'h1, d);
		chk("status history", 8'h03, d);
		reg_wr(2'h2, 8'h03);
		measure();
		@(negedge clk);
		chk("irq set", 3'h3, {to_n, pd_n, irq});
		reg_rd(2'h1, d);
		chk("status", 8'h01, d);
		chk("irq cleared", 1'b0, irq);
		clear_wd();
		@(negedge clk);
		chk("flags cleared", 2'h3, {to_n, pd_n});
		reg_wr(2'h2, 8'h00);
		measure();
		@(negedge clk);
		chk("irq masked", 1'b0, irq);
		reg_rd(2'h1, d);
		chk("status masked", 8'h01, d);
		$display("test interrupt done");
		test_done();
	end
endmodule
`default_nettype wire
